// ===== rtl/tcw_map.svh
// Register offsets, field positions, reset values and command bits of the timer channel
`ifndef TCW_MAP_SVH
`define TCW_MAP_SVH

// Register byte offsets
`define TCW_OFF_CTRL        8'h00
`define TCW_OFF_MODE        8'h04
`define TCW_OFF_CNT         8'h10
`define TCW_OFF_REG_A       8'h14
`define TCW_OFF_REG_B       8'h18
`define TCW_OFF_REG_C       8'h1C
`define TCW_OFF_STATUS      8'h20
`define TCW_OFF_BLOCK       8'hC0

// Channel control command bits
`define TCW_CTRL_CLK_EN     0
`define TCW_CTRL_CLK_DIS    1
`define TCW_CTRL_SOFT_TRIG  2
// Block control command bit
`define TCW_BLOCK_SYNC      0

// Channel mode fields
`define TCW_MODE_CLK_SEL    1:0
`define TCW_MODE_PATTERN    5:4
`define TCW_MODE_CPC_STOP   6
`define TCW_MODE_CPC_DIS    7
`define TCW_MODE_EDGE       9:8
`define TCW_MODE_PIN_SEL    10
`define TCW_MODE_EVT_SEL    11:10
`define TCW_MODE_EXT_TRG_EN 12
`define TCW_MODE_CPC_TRG    14
`define TCW_MODE_WAVE       15
`define TCW_MODE_LOAD_A     17:16
`define TCW_MODE_LOAD_B     19:18
`define TCW_MODE_ACT_A_CMPA 17:16
`define TCW_MODE_ACT_A_CMPC 19:18
`define TCW_MODE_ACT_A_EXT  21:20
`define TCW_MODE_ACT_A_SOFT 23:22
`define TCW_MODE_ACT_B_CMPB 25:24
`define TCW_MODE_ACT_B_CMPC 27:26
`define TCW_MODE_ACT_B_EXT  29:28
`define TCW_MODE_ACT_B_SOFT 31:30

// Status bits
`define TCW_ST_OVERFLOW     0
`define TCW_ST_OVERRUN      1
`define TCW_ST_CLK_EN       16
`define TCW_ST_PIN_A        17
`define TCW_ST_PIN_B        18
`define TCW_ST_CLK_RUN      19

// Reset values and counter limits
`define TCW_RST_WORD        32'h0000_0000
`define TCW_RST_HALF        16'h0000
`define TCW_CNT_MAX         16'hFFFF
`define TCW_CNT_ONE         16'h0001

`endif

// ===== rtl/tcw_pkg.sv
// Types shared by the timer channel: count patterns, edge selections and pin actions
package tcw_pkg;

  typedef enum logic [1:0] {
    TCW_PAT_UP_FULL   = 2'b00,
    TCW_PAT_UPDN_FULL = 2'b01,
    TCW_PAT_UP_RC     = 2'b10,
    TCW_PAT_UPDN_RC   = 2'b11
  } tcw_pattern_t;

  typedef enum logic [1:0] {
    TCW_EDGE_NONE    = 2'b00,
    TCW_EDGE_RISING  = 2'b01,
    TCW_EDGE_FALLING = 2'b10,
    TCW_EDGE_BOTH    = 2'b11
  } tcw_edge_t;

  typedef enum logic [1:0] {
    TCW_ACT_NONE   = 2'b00,
    TCW_ACT_SET    = 2'b01,
    TCW_ACT_CLEAR  = 2'b10,
    TCW_ACT_TOGGLE = 2'b11
  } tcw_action_t;

endpackage : tcw_pkg

// ===== rtl/tcw_channel.sv
// One 16-bit timer channel with capture and waveform modes and a plain register port
`timescale 1ns/1ps
`default_nettype none
`include "tcw_map.svh"

module tcw_channel (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_pin_a,
  input  wire logic        i_pin_b,
  input  wire logic [2:0]  i_ext_clk,
  output logic             o_pin_a,
  output logic             o_pin_a_oe,
  output logic             o_pin_b,
  output logic             o_pin_b_oe,
  output logic      [15:0] o_counter_value
);

  // Edge detector shared by all edge-selected events
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    tcw_pkg::tcw_edge_t e;
    e = tcw_pkg::tcw_edge_t'(sel);
    case (e)
      tcw_pkg::TCW_EDGE_RISING:  edge_hit = !prev && cur;
      tcw_pkg::TCW_EDGE_FALLING: edge_hit = prev && !cur;
      tcw_pkg::TCW_EDGE_BOTH:    edge_hit = prev ^ cur;
      default:                   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // Applies one programmed action to a pin level
  function automatic logic pin_act(input logic [1:0] act, input logic cur);
    tcw_pkg::tcw_action_t a;
    a = tcw_pkg::tcw_action_t'(act);
    case (a)
      tcw_pkg::TCW_ACT_SET:    pin_act = 1'b1;
      tcw_pkg::TCW_ACT_CLEAR:  pin_act = 1'b0;
      tcw_pkg::TCW_ACT_TOGGLE: pin_act = ~cur;
      default:                 pin_act = cur;
    endcase
  endfunction : pin_act

  logic [31:0] mode_q;
  logic [15:0] cnt_q;
  logic [15:0] ra_q;
  logic [15:0] rb_q;
  logic [15:0] rc_q;
  logic        dir_down_q;
  logic        clk_en_q;
  logic        clk_run_q;
  logic        trig_pend_q;
  logic        a_done_q;
  logic        ra_unread_q;
  logic        rb_unread_q;
  logic        ovf_q;
  logic        lovr_q;
  logic        pin_a_q;
  logic        pin_b_q;
  logic        prev_a_q;
  logic        prev_b_q;
  logic [2:0]  prev_x_q;
  logic [31:0] rdata_q;

  logic                 wave;
  tcw_pkg::tcw_pattern_t pattern;
  logic                 wr_ctrl;
  logic                 wr_block;
  logic                 rd_status;
  logic                 soft_trig;
  logic                 en_cmd;
  logic                 dis_cmd;
  logic                 tick_src;
  logic                 act_edge;
  logic                 updown;
  logic [15:0]          top;
  logic                 evt_sig_cur;
  logic                 evt_sig_prev;
  logic                 ext_evt;
  logic                 ext_trig;
  logic                 cmp_a;
  logic                 cmp_b;
  logic                 cmp_c;
  logic                 c_trig;
  logic                 any_trig;
  logic                 pin_b_out;
  logic                 load_a;
  logic                 load_b;
  logic                 at_top;

  // Mode decode
  assign wave    = mode_q[`TCW_MODE_WAVE];
  assign pattern = tcw_pkg::tcw_pattern_t'(mode_q[`TCW_MODE_PATTERN]);
  assign updown  = wave && (pattern == tcw_pkg::TCW_PAT_UPDN_FULL ||
                            pattern == tcw_pkg::TCW_PAT_UPDN_RC);
  assign top     = (pattern == tcw_pkg::TCW_PAT_UPDN_RC) ? rc_q : `TCW_CNT_MAX;

  // Register strobes and command bits
  assign wr_ctrl   = i_wr && (i_addr == `TCW_OFF_CTRL);
  assign wr_block  = i_wr && (i_addr == `TCW_OFF_BLOCK);
  assign rd_status = i_rd && (i_addr == `TCW_OFF_STATUS);
  assign soft_trig = (wr_ctrl && i_wdata[`TCW_CTRL_SOFT_TRIG]) ||
                     (wr_block && i_wdata[`TCW_BLOCK_SYNC]);
  assign dis_cmd   = wr_ctrl && i_wdata[`TCW_CTRL_CLK_DIS];
  assign en_cmd    = wr_ctrl && i_wdata[`TCW_CTRL_CLK_EN] && !dis_cmd;

  // Selected count clock: every bus cycle or a rising edge of one clock input
  always_comb begin
    case (mode_q[`TCW_MODE_CLK_SEL])
      2'h1:    tick_src = !prev_x_q[0] && i_ext_clk[0];
      2'h2:    tick_src = !prev_x_q[1] && i_ext_clk[1];
      2'h3:    tick_src = !prev_x_q[2] && i_ext_clk[2];
      default: tick_src = 1'b1;
    endcase
  end
  assign act_edge = tick_src && clk_en_q && clk_run_q;

  // External event source and edge
  always_comb begin
    if (!wave) begin
      evt_sig_cur  = mode_q[`TCW_MODE_PIN_SEL] ? i_pin_a : i_pin_b;
      evt_sig_prev = mode_q[`TCW_MODE_PIN_SEL] ? prev_a_q : prev_b_q;
    end else begin
      case (mode_q[`TCW_MODE_EVT_SEL])
        2'h1:    begin evt_sig_cur = i_ext_clk[0]; evt_sig_prev = prev_x_q[0]; end
        2'h2:    begin evt_sig_cur = i_ext_clk[1]; evt_sig_prev = prev_x_q[1]; end
        2'h3:    begin evt_sig_cur = i_ext_clk[2]; evt_sig_prev = prev_x_q[2]; end
        default: begin evt_sig_cur = i_pin_b;      evt_sig_prev = prev_b_q;    end
      endcase
    end
  end
  // Edge field zero yields no event in either mode
  assign ext_evt  = edge_hit(mode_q[`TCW_MODE_EDGE], evt_sig_prev, evt_sig_cur);
  assign ext_trig = ext_evt && (!wave || mode_q[`TCW_MODE_EXT_TRG_EN]);

  // Compare events, taken on the active edge that leaves the matching value
  assign cmp_c     = act_edge && (cnt_q == rc_q);
  assign cmp_a     = act_edge && wave && (cnt_q == ra_q);
  assign pin_b_out = wave && (mode_q[`TCW_MODE_EVT_SEL] != 2'h0);
  assign cmp_b     = act_edge && pin_b_out && (cnt_q == rb_q);
  // In waveform mode pattern 2 resets itself on the match and patterns 0 and 1 never take the trigger
  assign c_trig    = cmp_c && mode_q[`TCW_MODE_CPC_TRG] &&
                     (!wave || pattern == tcw_pkg::TCW_PAT_UPDN_RC);
  // Triggers are ignored while the clock is disabled
  assign any_trig  = (soft_trig || ext_trig || c_trig) && clk_en_q;

  assign at_top = (cnt_q == top);

  // Configuration and compare registers; A and B are writable in waveform mode only
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      mode_q <= `TCW_RST_WORD;
      rc_q   <= `TCW_RST_HALF;
    end else begin
      if (i_wr && i_addr == `TCW_OFF_MODE) begin
        mode_q <= i_wdata;
      end
      if (i_wr && i_addr == `TCW_OFF_REG_C) begin
        rc_q <= i_wdata[15:0];
      end
    end
  end

  // Clock enable and run state
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      clk_en_q  <= 1'b0;
      clk_run_q <= 1'b0;
    end else begin
      if (dis_cmd || (cmp_c && wave && mode_q[`TCW_MODE_CPC_DIS])) begin
        clk_en_q <= 1'b0;
      end else if (en_cmd) begin
        clk_en_q <= 1'b1;
      end
      if (any_trig) begin
        clk_run_q <= 1'b1;
      end else if (cmp_c && wave && mode_q[`TCW_MODE_CPC_STOP]) begin
        clk_run_q <= 1'b0;
      end
    end
  end

  // Pending trigger waits for the next active count edge
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      trig_pend_q <= 1'b0;
    end else if (dis_cmd) begin
      trig_pend_q <= 1'b0;
    end else if (any_trig) begin
      trig_pend_q <= 1'b1;
    end else if (act_edge) begin
      trig_pend_q <= 1'b0;
    end
  end

  // Counter and direction; a pending trigger outranks the compare C reload
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_q      <= `TCW_RST_HALF;
      dir_down_q <= 1'b0;
    end else if (act_edge) begin
      if (trig_pend_q) begin
        if (updown) begin
          dir_down_q <= ~dir_down_q;
          cnt_q      <= dir_down_q ? cnt_q + `TCW_CNT_ONE : cnt_q - `TCW_CNT_ONE;
        end else begin
          cnt_q      <= `TCW_RST_HALF;
          dir_down_q <= 1'b0;
        end
      end else if (wave && pattern == tcw_pkg::TCW_PAT_UP_RC && cmp_c) begin
        cnt_q <= `TCW_RST_HALF;
      end else if (updown) begin
        if (!dir_down_q && at_top) begin
          dir_down_q <= 1'b1;
          cnt_q      <= cnt_q - `TCW_CNT_ONE;
        end else if (dir_down_q && cnt_q == `TCW_RST_HALF) begin
          dir_down_q <= 1'b0;
          cnt_q      <= cnt_q + `TCW_CNT_ONE;
        end else begin
          cnt_q <= dir_down_q ? cnt_q - `TCW_CNT_ONE : cnt_q + `TCW_CNT_ONE;
        end
      end else begin
        cnt_q <= cnt_q + `TCW_CNT_ONE;
      end
    end
  end

  // Capture loads on pin A edges, ordered A then B
  assign load_a = !wave && !a_done_q &&
                  edge_hit(mode_q[`TCW_MODE_LOAD_A], prev_a_q, i_pin_a);
  assign load_b = !wave && a_done_q &&
                  edge_hit(mode_q[`TCW_MODE_LOAD_B], prev_a_q, i_pin_a);

  // Load sequencing flag, cleared by any trigger
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      a_done_q <= 1'b0;
    end else if (any_trig) begin
      a_done_q <= 1'b0;
    end else if (load_a) begin
      a_done_q <= 1'b1;
    end else if (load_b) begin
      a_done_q <= 1'b0;
    end
  end

  // Registers A and B: capture in capture mode, software writes in waveform mode
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ra_q <= `TCW_RST_HALF;
      rb_q <= `TCW_RST_HALF;
    end else begin
      if (load_a) begin
        ra_q <= cnt_q;
      end else if (wave && i_wr && i_addr == `TCW_OFF_REG_A) begin
        ra_q <= i_wdata[15:0];
      end
      if (load_b) begin
        rb_q <= cnt_q;
      end else if (wave && i_wr && i_addr == `TCW_OFF_REG_B) begin
        rb_q <= i_wdata[15:0];
      end
    end
  end

  // Unread tracking; a load in the read cycle keeps the value unread
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ra_unread_q <= 1'b0;
      rb_unread_q <= 1'b0;
    end else begin
      if (load_a) begin
        ra_unread_q <= 1'b1;
      end else if (i_rd && i_addr == `TCW_OFF_REG_A) begin
        ra_unread_q <= 1'b0;
      end
      if (load_b) begin
        rb_unread_q <= 1'b1;
      end else if (i_rd && i_addr == `TCW_OFF_REG_B) begin
        rb_unread_q <= 1'b0;
      end
    end
  end

  // Sticky status flags, cleared by a status read; a new event wins the clear
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ovf_q  <= 1'b0;
      lovr_q <= 1'b0;
    end else begin
      if (act_edge && !trig_pend_q && !updown && cnt_q == `TCW_CNT_MAX) begin
        ovf_q <= 1'b1;
      end else if (rd_status) begin
        ovf_q <= 1'b0;
      end
      if ((load_a && ra_unread_q) || (load_b && rb_unread_q)) begin
        lovr_q <= 1'b1;
      end else if (rd_status) begin
        lovr_q <= 1'b0;
      end
    end
  end

  // Output controller; later events in this chain win over earlier ones
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else if (wave) begin
      pin_a_q <= pin_act(mode_q[`TCW_MODE_ACT_A_SOFT] & {2{soft_trig}},
                 pin_act(mode_q[`TCW_MODE_ACT_A_EXT]  & {2{ext_evt}},
                 pin_act(mode_q[`TCW_MODE_ACT_A_CMPC] & {2{cmp_c}},
                 pin_act(mode_q[`TCW_MODE_ACT_A_CMPA] & {2{cmp_a}}, pin_a_q))));
      if (pin_b_out) begin
        pin_b_q <= pin_act(mode_q[`TCW_MODE_ACT_B_SOFT] & {2{soft_trig}},
                   pin_act(mode_q[`TCW_MODE_ACT_B_EXT]  & {2{ext_evt}},
                   pin_act(mode_q[`TCW_MODE_ACT_B_CMPC] & {2{cmp_c}},
                   pin_act(mode_q[`TCW_MODE_ACT_B_CMPB] & {2{cmp_b}}, pin_b_q))));
      end
    end
  end

  // Input history for edge detection
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
      prev_x_q <= 3'h0;
    end else begin
      prev_a_q <= i_pin_a;
      prev_b_q <= i_pin_b;
      prev_x_q <= i_ext_clk;
    end
  end

  // Read data, valid the cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rdata_q <= `TCW_RST_WORD;
    end else if (i_rd) begin
      if (i_addr == `TCW_OFF_MODE) begin
        rdata_q <= mode_q;
      end else if (i_addr == `TCW_OFF_CNT) begin
        rdata_q <= {16'h0000, cnt_q};
      end else if (i_addr == `TCW_OFF_REG_A) begin
        rdata_q <= {16'h0000, ra_q};
      end else if (i_addr == `TCW_OFF_REG_B) begin
        rdata_q <= {16'h0000, rb_q};
      end else if (i_addr == `TCW_OFF_REG_C) begin
        rdata_q <= {16'h0000, rc_q};
      end else if (i_addr == `TCW_OFF_STATUS) begin
        rdata_q <= {12'h000, clk_run_q, pin_b_q, pin_a_q, clk_en_q,
                    14'h0000, lovr_q, ovf_q};
      end else begin
        rdata_q <= `TCW_RST_WORD;
      end
    end else begin
      rdata_q <= `TCW_RST_WORD;
    end
  end

  // Port drive
  assign o_rdata         = rdata_q;
  assign o_counter_value = cnt_q;
  assign o_pin_a         = pin_a_q;
  assign o_pin_a_oe      = wave;
  assign o_pin_b         = pin_b_q;
  assign o_pin_b_oe      = pin_b_out;

  // Checks
  a_trig_resets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    trig_pend_q && act_edge && !updown |=> cnt_q == 16'h0000)
    else $error("trigger did not reset the counter");
  a_soft_pend: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    wr_ctrl && i_wdata[2] && clk_en_q && !dis_cmd |=> trig_pend_q && clk_run_q)
    else $error("soft trigger not registered");
  a_disabled_ign: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !clk_en_q && !en_cmd |=> !clk_en_q && $stable(cnt_q))
    else $error("disabled clock moved");
  a_pat0_wrap: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    act_edge && !trig_pend_q && !updown && cnt_q == 16'hFFFF |=> ovf_q && cnt_q == 16'h0000)
    else $error("wrap did not flag overflow");
  a_pat2_reset: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    wave && pattern == tcw_pkg::TCW_PAT_UP_RC && cmp_c |=> cnt_q == 16'h0000)
    else $error("pattern 2 missed reset at register C");
  a_overrun_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    load_a && ra_unread_q |=> lovr_q && ra_q == $past(cnt_q))
    else $error("overrun not flagged");
  a_order_b: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    load_b |-> !load_a ##1 !a_done_q)
    else $error("capture B out of order");
  a_pin_b_free: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    wave && mode_q[11:10] == 2'h0 |-> !o_pin_b_oe ##1 $stable(pin_b_q))
    else $error("pin B driven while event source");
  a_stop_cmp: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    cmp_c && wave && mode_q[6] && !any_trig |=> !clk_run_q)
    else $error("compare stop ignored");
  c_updown_turn: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    updown && act_edge && at_top && !dir_down_q);
  c_capture_pair: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    load_a ##[1:20] load_b);
  c_trig_reverse: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    updown && trig_pend_q && act_edge);

endmodule : tcw_channel
`default_nettype wire

// ===== verif/tcw_pin_model.sv
// Far-side model of the channel pins and the three external clock sources
`timescale 1ns/1ps
`default_nettype none
module tcw_pin_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_a_lvl,
  input  wire logic       i_b_lvl,
  input  wire logic       i_a_out,
  input  wire logic       i_a_oe,
  input  wire logic       i_b_out,
  input  wire logic       i_b_oe,
  output logic            o_a,
  output logic            o_b,
  output logic      [2:0] o_ext_clk
);
  logic [4:0] div_q;

  // Slow divider so that every source level lasts several bus cycles
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // Each external level is held four bus cycles or more
  assign o_ext_clk = div_q[4:2];
  // The driving party owns the wire, the outside source otherwise
  assign o_a = i_a_oe ? i_a_out : i_a_lvl;
  assign o_b = i_b_oe ? i_b_out : i_b_lvl;
endmodule : tcw_pin_model
`default_nettype wire

// ===== verif/test_timer_channel_capture_waveform.sv
// Self-checking testbench for the timer channel with its pin model
`timescale 1ns/1ps
`default_nettype none
`include "tcw_map.svh"
module test_timer_channel_capture_waveform;
  logic        mclk  = 1'b0;
  logic        rstn  = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        a_lvl = 1'b0;
  logic        b_lvl = 1'b0;
  logic [31:0] rdata;
  logic        pa, pa_oe, pb, pb_oe, a_w, b_w;
  logic [2:0]  ext_clk;
  logic [15:0] cv;
  int          failures = 0;
  int          n_checks = 0;

  // Bus clock at 25 MHz
  always #20 mclk = ~mclk;

  tcw_channel u_tcw_channel (.i_mclk(mclk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin_a(a_w), .i_pin_b(b_w), .i_ext_clk(ext_clk),
    .o_pin_a(pa), .o_pin_a_oe(pa_oe), .o_pin_b(pb), .o_pin_b_oe(pb_oe), .o_counter_value(cv));
  tcw_pin_model u_tcw_pin_model (.i_mclk(mclk), .i_rstn(rstn), .i_a_lvl(a_lvl), .i_b_lvl(b_lvl),
    .i_a_out(pa), .i_a_oe(pa_oe), .i_b_out(pb), .i_b_oe(pb_oe), .o_a(a_w), .o_b(b_w),
    .o_ext_clk(ext_clk));

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // One write cycle, then one idle cycle
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask : wrr

  // One read cycle; data taken in the following cycle
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask : rdr

  // Issue a trigger; with the bus clock counting, the counter reads zero one cycle later
  task automatic trg(input logic [7:0] a);
    wrr(a, (a == `TCW_OFF_BLOCK) ? 32'h0000_0001 : 32'h0000_0004);
    cyc(1);
    chk("counter after trigger", 32'h0, {16'h0, cv});
  endtask : trg

  // Largest counter value seen over n cycles
  task automatic peak(input int n, output logic [15:0] m);
    m = 16'h0000;
    repeat (n) begin
      @(posedge mclk);
      if (cv > m) begin
        m = cv;
      end
    end
  endtask : peak

  task automatic t_reset;
    logic [31:0] d;
    rdr(`TCW_OFF_MODE, d);
    chk("mode reset", 32'h0, d);
    rdr(8'h30, d);
    chk("unmapped read", 32'h0, d);
    chk("pin enables in capture", 32'h0, {30'h0, pa_oe, pb_oe});
  endtask : t_reset

  task automatic t_count;
    wrr(`TCW_OFF_MODE, 32'h0000_8000);
    wrr(`TCW_OFF_CTRL, 32'h0000_0001);
    trg(`TCW_OFF_CTRL);
    cyc(10);
    chk("count up", 32'hA, {16'h0, cv});
    wrr(`TCW_OFF_CTRL, 32'h0000_0000);
    cyc(1);
    chk("zero command", 32'hD, {16'h0, cv});
    trg(`TCW_OFF_BLOCK);
  endtask : t_count

  task automatic t_pat2;
    wrr(`TCW_OFF_REG_C, 32'h0000_0005);
    wrr(`TCW_OFF_MODE, 32'h0000_8020);
    trg(`TCW_OFF_CTRL);
    cyc(5);
    chk("count to compare", 32'h5, {16'h0, cv});
    cyc(1);
    chk("reset on compare", 32'h0, {16'h0, cv});
  endtask : t_pat2

  task automatic t_stop;
    logic [15:0] a;
    logic [31:0] d;
    wrr(`TCW_OFF_REG_C, 32'h0000_0003);
    wrr(`TCW_OFF_MODE, 32'h0000_8040);
    trg(`TCW_OFF_CTRL);
    cyc(8);
    a = cv;
    chk("stop point", 32'h1, 32'(a == 16'h3 || a == 16'h4));
    wrr(`TCW_OFF_CTRL, 32'h0000_0002);
    wrr(`TCW_OFF_CTRL, 32'h0000_0004);
    cyc(4);
    chk("trigger while disabled", {16'h0, a}, {16'h0, cv});
    rdr(`TCW_OFF_STATUS, d);
    chk("clock enabled flag", 32'h0, 32'(d[`TCW_ST_CLK_EN]));
    chk("clock running flag", 32'h0, 32'(d[`TCW_ST_CLK_RUN]));
    wrr(`TCW_OFF_CTRL, 32'h0000_0001);
  endtask : t_stop

  task automatic t_updown;
    logic [15:0] p, d, e;
    logic        top;
    wrr(`TCW_OFF_REG_C, 32'h0000_0004);
    wrr(`TCW_OFF_MODE, 32'h0000_8030);
    wrr(`TCW_OFF_CTRL, 32'h0000_0004);
    cyc(2);
    top = 1'b0;
    repeat (12) begin
      p = cv;
      @(posedge mclk);
      top = top | (cv == 16'h4);
      chk("single step in range", 32'h1, 32'((cv - p == 16'h1 || p - cv == 16'h1) && cv <= 16'h4));
    end
    chk("reached compare", 32'h1, 32'(top));
    wrr(`TCW_OFF_REG_C, 32'h0000_00C8);
    cyc(12);
    p = cv;
    @(posedge mclk);
    d = p - cv;
    wrr(`TCW_OFF_CTRL, 32'h0000_0004);
    cyc(3);
    p = cv;
    @(posedge mclk);
    e = cv - p;
    chk("direction reversed", {16'h0, d}, {16'h0, e});
  endtask : t_updown

  task automatic t_capture;
    logic [31:0] s, ra, rb;
    wrr(`TCW_OFF_MODE, 32'h0009_0000);
    a_lvl <= 1'b1;
    cyc(7);
    a_lvl <= 1'b0;
    cyc(3);
    a_lvl <= 1'b1;
    cyc(5);
    a_lvl <= 1'b0;
    cyc(3);
    rdr(`TCW_OFF_STATUS, s);
    chk("load overrun", 32'h1, 32'(s[`TCW_ST_OVERRUN]));
    rdr(`TCW_OFF_REG_A, ra);
    rdr(`TCW_OFF_REG_B, rb);
    chk("capture span", 32'h5, rb - ra);
    wrr(`TCW_OFF_MODE, 32'h0000_0100);
    cyc(20);
    b_lvl <= 1'b1;
    cyc(4);
    chk("pin trigger", 32'h1, 32'(cv < 16'h4));
    b_lvl <= 1'b0;
  endtask : t_capture

  // Compare C restart in capture mode, then external event triggers in waveform mode
  task automatic t_events;
    logic [15:0] m;
    wrr(`TCW_OFF_MODE, 32'h0000_4000);
    wrr(`TCW_OFF_REG_C, 32'h0000_0004);
    trg(`TCW_OFF_CTRL);
    cyc(10);
    peak(12, m);
    chk("compare C restart peak", 32'h5, {16'h0, m});
    wrr(`TCW_OFF_MODE, 32'h0030_9500);
    cyc(10);
    peak(16, m);
    chk("event trigger peak", 32'h7, {16'h0, m});
  endtask : t_events

  task automatic t_wave;
    logic [31:0] s;
    wrr(`TCW_OFF_MODE, 32'hC040_8400);
    chk("enables in waveform", 32'h3, {30'h0, pa_oe, pb_oe});
    wrr(`TCW_OFF_CTRL, 32'h0000_0004);
    cyc(3);
    chk("soft actions", 32'h3, {30'h0, pa, pb});
    wrr(`TCW_OFF_MODE, 32'hC040_8000);
    chk("pin b freed", 32'h2, {30'h0, pa_oe, pb_oe});
    rdr(`TCW_OFF_STATUS, s);
    cyc(65540);
    rdr(`TCW_OFF_STATUS, s);
    chk("overflow flag", 32'h1, 32'(s[`TCW_ST_OVERFLOW]));
  endtask : t_wave

  // Verdict and end of run
  task automatic summarize;
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_count();
    t_pat2();
    t_stop();
    t_updown();
    t_capture();
    t_events();
    t_wave();
    summarize();
  end

  // Watchdog above the roughly 66,000 cycles that the scenarios take
  initial begin
    repeat (80000) @(posedge mclk);
    failures++;
    summarize();
  end
endmodule : test_timer_channel_capture_waveform
`default_nettype wire
